//--- igp_map.svh
// register map, field positions and reset values of the gpio ports
`ifndef IGP_MAP_SVH
`define IGP_MAP_SVH
`define IGP_BASE_P0 16'hfca0
`define IGP_BASE_P1 16'hfcc0
`define IGP_BASE_P2 16'hfce0
`define IGP_WIN_MASK 16'hffe0
`define IGP_IDX_DIR 5'h00
`define IGP_IDX_OUT 5'h01
`define IGP_IDX_LVL 5'h02
`define IGP_IDX_FALL 5'h03
`define IGP_IDX_RISE 5'h04
`define IGP_IDX_PEND 5'h05
`define IGP_IDX_SET 5'h06
`define IGP_IDX_CLR 5'h07
`define IGP_IDX_MAP 5'h08
`define IGP_IDX_ENGA 5'h09
`define IGP_IDX_ENGB 5'h0a
`define IGP_IDX_PSEL 5'h0b
`define IGP_RST_VAL 16'h0000
`define IGP_ENGB_DAT_HI 15
`define IGP_ENGB_DAT_LO 12
`define IGP_ENGB_PIN_HI 11
`define IGP_ENGB_PIN_LO 8
`define IGP_ENGA_DAT_HI 7
`define IGP_ENGA_DAT_LO 4
`define IGP_ENGA_PIN_HI 3
`define IGP_ENGA_PIN_LO 0
`endif

//--- igp_pkg.sv
// types shared by the gpio port files
package igp_pkg;
	typedef logic [15:0] igp_word_t;
	typedef logic [3:0] igp_idx_t;
endpackage : igp_pkg

//--- igp_bus_if.sv
// register access carrier between the top and each port
interface igp_bus_if;
	logic [4:0] idx;
	logic [15:0] wdata;
	logic wr;
	logic rd;
	logic [15:0] rdata;
	modport ctl (output idx, output wdata, output wr, output rd, input rdata);
	modport port (input idx, input wdata, input wr, input rd, output rdata);
endinterface : igp_bus_if

//--- igp_port.sv
// one gpio port: registers, pin drive, edge capture and bit engines
`include "igp_map.svh"
module igp_port
	import igp_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic arst_n,
	igp_bus_if.port bus,
	input wire logic [WIDTH-1:0] pin_sync,
	output logic [WIDTH-1:0] pin_out,
	output logic [WIDTH-1:0] pin_oe_n,
	output logic [WIDTH-1:0] psel,
	output logic irq
);
	logic [WIDTH-1:0] dir_ff, out_ff, fall_ff, rise_ff, pend_ff, psel_ff, prev_ff;
	logic [15:0] map_ff;
	logic [WIDTH-1:0] nxt_dir, nxt_psel, oe_n_ff;
	logic [WIDTH-1:0] nxt_out, nxt_pend;
	logic [WIDTH-1:0] rise_ev, fall_ev, clr_mask;
	logic [WIDTH-1:0] eng_a_bit, eng_b_bit;
	logic [15:0] lvl16, rd_mux, eng_a_rd, eng_b_rd;
	logic [4:0] idx;
	igp_idx_t a_dat, a_pin, b_dat, b_pin;
	logic w_dir, w_out, w_fall, w_rise, w_pend, w_set, w_clr, w_map, w_a, w_b, w_psel;
	logic irq_ff;

	assign idx = bus.idx;
	assign w_dir = bus.wr && idx == `IGP_IDX_DIR;
	assign w_out = bus.wr && idx == `IGP_IDX_OUT;
	assign w_fall = bus.wr && idx == `IGP_IDX_FALL;
	assign w_rise = bus.wr && idx == `IGP_IDX_RISE;
	assign w_pend = bus.wr && idx == `IGP_IDX_PEND;
	assign w_set = bus.wr && idx == `IGP_IDX_SET;
	assign w_clr = bus.wr && idx == `IGP_IDX_CLR;
	assign w_map = bus.wr && idx == `IGP_IDX_MAP;
	assign w_a = bus.wr && idx == `IGP_IDX_ENGA;
	assign w_b = bus.wr && idx == `IGP_IDX_ENGB;
	assign w_psel = bus.wr && idx == `IGP_IDX_PSEL;
	assign nxt_dir = w_dir ? bus.wdata[WIDTH-1:0] : dir_ff;
	assign nxt_psel = w_psel ? bus.wdata[WIDTH-1:0] : psel_ff;

	assign a_dat = map_ff[`IGP_ENGA_DAT_HI:`IGP_ENGA_DAT_LO];
	assign a_pin = map_ff[`IGP_ENGA_PIN_HI:`IGP_ENGA_PIN_LO];
	assign b_dat = map_ff[`IGP_ENGB_DAT_HI:`IGP_ENGB_DAT_LO];
	assign b_pin = map_ff[`IGP_ENGB_PIN_HI:`IGP_ENGB_PIN_LO];

	// pins beyond the port width read as zero
	assign lvl16 = 16'(pin_sync);

	// engine writes: decoded one-hot pin target
	always_comb begin
		eng_a_bit = '0;
		eng_b_bit = '0;
		for (int i = 0; i < WIDTH; i++) begin
			eng_a_bit[i] = (a_pin == 4'(i));
			eng_b_bit[i] = (b_pin == 4'(i));
		end
	end

	always_comb begin
		nxt_out = out_ff;
		if (w_out)
			nxt_out = bus.wdata[WIDTH-1:0];
		if (w_set)
			nxt_out = out_ff | bus.wdata[WIDTH-1:0];
		if (w_clr)
			nxt_out = out_ff & ~bus.wdata[WIDTH-1:0];
		if (w_a)
			nxt_out = bus.wdata[a_dat] ? (out_ff | eng_a_bit) : (out_ff & ~eng_a_bit);
		if (w_b)
			nxt_out = bus.wdata[b_dat] ? (out_ff | eng_b_bit) : (out_ff & ~eng_b_bit);
	end

	// edges seen even on output and peripheral pins
	assign rise_ev = pin_sync & ~prev_ff & rise_ff;
	assign fall_ev = ~pin_sync & prev_ff & fall_ff;
	assign clr_mask = w_pend ? bus.wdata[WIDTH-1:0] : '0;
	// a new edge in the clearing cycle survives the clear
	assign nxt_pend = (pend_ff & ~clr_mask) | rise_ev | fall_ev;

	assign eng_a_rd = 16'(lvl16[a_pin]) << a_dat;
	assign eng_b_rd = 16'(lvl16[b_pin]) << b_dat;

	always_comb begin
		unique case (idx)
			`IGP_IDX_DIR: rd_mux = 16'(dir_ff);
			`IGP_IDX_OUT: rd_mux = 16'(out_ff);
			`IGP_IDX_LVL: rd_mux = lvl16;
			`IGP_IDX_FALL: rd_mux = 16'(fall_ff);
			`IGP_IDX_RISE: rd_mux = 16'(rise_ff);
			`IGP_IDX_PEND: rd_mux = 16'(pend_ff);
			`IGP_IDX_MAP: rd_mux = map_ff;
			`IGP_IDX_ENGA: rd_mux = eng_a_rd;
			`IGP_IDX_ENGB: rd_mux = eng_b_rd;
			`IGP_IDX_PSEL: rd_mux = 16'(psel_ff);
			default: rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dir_ff <= '0;
			out_ff <= '0;
			fall_ff <= '0;
			rise_ff <= '0;
			pend_ff <= '0;
			psel_ff <= '0;
			prev_ff <= '0;
			map_ff <= `IGP_RST_VAL;
			oe_n_ff <= '1;
			irq_ff <= 1'b0;
		end else begin
			dir_ff <= nxt_dir;
			if (w_fall)
				fall_ff <= bus.wdata[WIDTH-1:0];
			if (w_rise)
				rise_ff <= bus.wdata[WIDTH-1:0];
			psel_ff <= nxt_psel;
			// built from next values so the enable moves with the registers
			oe_n_ff <= ~(nxt_dir & ~nxt_psel);
			if (w_map)
				map_ff <= bus.wdata;
			out_ff <= nxt_out;
			pend_ff <= nxt_pend;
			prev_ff <= pin_sync;
			irq_ff <= |nxt_pend;
		end
	end

	// zero when not read, so the top may or the ports and register once
	assign bus.rdata = bus.rd ? rd_mux : 16'h0000;
	assign pin_out = out_ff;
	// drive only when software owns the pin as an output
	assign pin_oe_n = oe_n_ff;
	assign psel = psel_ff;
	assign irq = irq_ff;

	a_irq_follows: assert property (@(posedge clk) disable iff (!arst_n) irq == |pend_ff)
		else $error("irq does not follow pending bits");
	a_rise_sets: assert property (@(posedge clk) disable iff (!arst_n)
		(rise_ev != '0) |=> ((pend_ff & $past(rise_ev)) == $past(rise_ev)))
		else $error("rising edge lost");
	a_fall_sets: assert property (@(posedge clk) disable iff (!arst_n)
		(fall_ev != '0) |=> ((pend_ff & $past(fall_ev)) == $past(fall_ev)))
		else $error("falling edge lost");
	a_w1c_keep: assert property (@(posedge clk) disable iff (!arst_n)
		w_pend |=> ((pend_ff & $past(pend_ff & ~bus.wdata[WIDTH-1:0])) == $past(pend_ff & ~bus.wdata[WIDTH-1:0])))
		else $error("pending bit written zero changed");
	a_set_bits: assert property (@(posedge clk) disable iff (!arst_n)
		w_set |=> out_ff == ($past(out_ff) | $past(bus.wdata[WIDTH-1:0])))
		else $error("set strobe wrong");
	a_clr_bits: assert property (@(posedge clk) disable iff (!arst_n)
		w_clr |=> out_ff == ($past(out_ff) & ~$past(bus.wdata[WIDTH-1:0])))
		else $error("clear strobe wrong");
	a_input_undriven: assert property (@(posedge clk) disable iff (!arst_n)
		((~dir_ff) & ~pin_oe_n) == '0)
		else $error("input pin driven");
	a_unused_zero: assert property (@(posedge clk) disable iff (!arst_n)
		(bus.rd && idx > `IGP_IDX_PSEL) |-> bus.rdata == 16'h0000)
		else $error("unused index not zero");
	a_dir_read: assert property (@(posedge clk) disable iff (!arst_n)
		(bus.rd && idx == `IGP_IDX_DIR) |-> bus.rdata == 16'(dir_ff))
		else $error("direction readback wrong");
endmodule : igp_port

//--- igp_gpio.sv
`include "igp_map.svh"
module igp_gpio
	import igp_pkg::*;
#(
	parameter int P0_WIDTH = 16,
	parameter int P1_WIDTH = 16,
	parameter int P2_WIDTH = 14
) (
	input wire logic CLOCK,
	input wire logic ARST_N,
	input wire logic [15:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	input wire logic [P0_WIDTH-1:0] P0_IN,
	output logic [P0_WIDTH-1:0] P0_OUT,
	output logic [P0_WIDTH-1:0] P0_OE_N,
	output logic [P0_WIDTH-1:0] P0_PSEL,
	output logic P0_IRQ,
	input wire logic [P1_WIDTH-1:0] P1_IN,
	output logic [P1_WIDTH-1:0] P1_OUT,
	output logic [P1_WIDTH-1:0] P1_OE_N,
	output logic [P1_WIDTH-1:0] P1_PSEL,
	output logic P1_IRQ,
	input wire logic [P2_WIDTH-1:0] P2_IN,
	output logic [P2_WIDTH-1:0] P2_OUT,
	output logic [P2_WIDTH-1:0] P2_OE_N,
	output logic [P2_WIDTH-1:0] P2_PSEL,
	output logic P2_IRQ
);
	// two-stage synchronisers; stage one feeds stage two only
	logic [P0_WIDTH-1:0] s0a_ff, s0b_ff;
	logic [P1_WIDTH-1:0] s1a_ff, s1b_ff;
	logic [P2_WIDTH-1:0] s2a_ff, s2b_ff;
	logic hit0, hit1, hit2;
	logic miss_ff;
	logic [15:0] rdata_ff;

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			s0a_ff <= '0;
			s0b_ff <= '0;
			s1a_ff <= '0;
			s1b_ff <= '0;
			s2a_ff <= '0;
			s2b_ff <= '0;
		end else begin
			s0a_ff <= P0_IN;
			s0b_ff <= s0a_ff;
			s1a_ff <= P1_IN;
			s1b_ff <= s1a_ff;
			s2a_ff <= P2_IN;
			s2b_ff <= s2a_ff;
		end
	end

	assign hit0 = (ADDR & `IGP_WIN_MASK) == `IGP_BASE_P0;
	assign hit1 = (ADDR & `IGP_WIN_MASK) == `IGP_BASE_P1;
	assign hit2 = (ADDR & `IGP_WIN_MASK) == `IGP_BASE_P2;

	igp_bus_if b0 ();
	igp_bus_if b1 ();
	igp_bus_if b2 ();

	assign b0.idx = ADDR[4:0];
	assign b0.wdata = WDATA;
	assign b0.wr = WR && hit0;
	assign b0.rd = RD && hit0;
	assign b1.idx = ADDR[4:0];
	assign b1.wdata = WDATA;
	assign b1.wr = WR && hit1;
	assign b1.rd = RD && hit1;
	assign b2.idx = ADDR[4:0];
	assign b2.wdata = WDATA;
	assign b2.wr = WR && hit2;
	assign b2.rd = RD && hit2;

	// three independent ports, widths per port
	igp_port #(.WIDTH(P0_WIDTH)) u_port0 (
		.clk(CLOCK),
		.arst_n(ARST_N),
		.bus(b0.port),
		.pin_sync(s0b_ff),
		.pin_out(P0_OUT),
		.pin_oe_n(P0_OE_N),
		.psel(P0_PSEL),
		.irq(P0_IRQ)
	);
	igp_port #(.WIDTH(P1_WIDTH)) u_port1 (
		.clk(CLOCK),
		.arst_n(ARST_N),
		.bus(b1.port),
		.pin_sync(s1b_ff),
		.pin_out(P1_OUT),
		.pin_oe_n(P1_OE_N),
		.psel(P1_PSEL),
		.irq(P1_IRQ)
	);
	igp_port #(.WIDTH(P2_WIDTH)) u_port2 (
		.clk(CLOCK),
		.arst_n(ARST_N),
		.bus(b2.port),
		.pin_sync(s2b_ff),
		.pin_out(P2_OUT),
		.pin_oe_n(P2_OE_N),
		.psel(P2_PSEL),
		.irq(P2_IRQ)
	);

	// ports return zero unless read, so an or of the three is the mux
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			miss_ff <= 1'b0;
			rdata_ff <= 16'h0000;
		end else begin
			miss_ff <= RD && !(hit0 || hit1 || hit2);
			rdata_ff <= b0.rdata | b1.rdata | b2.rdata;
		end
	end

	assign RDATA = rdata_ff;

	a_unmapped_zero: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		miss_ff |-> RDATA == 16'h0000)
		else $error("unmapped read not zero");
	a_sync_delay: assert property (@(posedge CLOCK) disable iff (!ARST_N)
		$past(ARST_N, 2) |-> s0b_ff == $past(P0_IN, 2))
		else $error("synchroniser delay wrong");
endmodule : igp_gpio

//--- igp_pin_model.sv
// external devices on the port pins
module igp_pin_model #(
	parameter int W = 16
) (
	input wire logic [W-1:0] drv,
	input wire logic [W-1:0] oe_n,
	input wire logic [W-1:0] ext,
	output logic [W-1:0] pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// no contention model: the port wins wherever it drives
	assign pin = (drv & ~oe_n) | (ext & oe_n);
endmodule : igp_pin_model

//--- test_interruptible_gpio_ports.sv
// self-checking bench for the three gpio ports
`include "igp_map.svh"
module test_interruptible_gpio_ports;
	import igp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, arst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
	logic [15:0] addr = 16'h0, wdata = 16'h0, rdata;
	logic [15:0] ext0 = 16'h1234, ext1 = 16'h0, p0, p1, out0, out1, oen0, oen1, psel0, psel1;
	logic [13:0] ext2 = 14'h0, p2, out2, oen2, psel2;
	logic irq0, irq1, irq2;
	int err_count = 0, check_count = 0;
	always #10 clk = ~clk;
	igp_gpio u_igp_gpio (.CLOCK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
		.RDATA(rdata), .P0_IN(p0), .P0_OUT(out0), .P0_OE_N(oen0), .P0_PSEL(psel0), .P0_IRQ(irq0),
		.P1_IN(p1), .P1_OUT(out1), .P1_OE_N(oen1), .P1_PSEL(psel1), .P1_IRQ(irq1),
		.P2_IN(p2), .P2_OUT(out2), .P2_OE_N(oen2), .P2_PSEL(psel2), .P2_IRQ(irq2));
	igp_pin_model #(.W(16)) u_igp_pin_model0 (.drv(out0), .oe_n(oen0), .ext(ext0), .pin(p0));
	igp_pin_model #(.W(16)) u_igp_pin_model1 (.drv(out1), .oe_n(oen1), .ext(ext1), .pin(p1));
	igp_pin_model #(.W(14)) u_igp_pin_model2 (.drv(out2), .oe_n(oen2), .ext(ext2), .pin(p2));
	function automatic logic [15:0] ad(input int p, input logic [4:0] i);
		return (p == 0 ? `IGP_BASE_P0 : p == 1 ? `IGP_BASE_P1 : `IGP_BASE_P2) | 16'(i);
	endfunction : ad
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : wt
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		chk(rdata, exp);
	endtask : rd
	task automatic give_verdict;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		give_verdict();
	end
	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		wt(3);
		chk(oen0, 16'hffff);
		chk(psel1, 16'h0);
		chk(16'(psel2), 16'h0);
		rd(ad(0, `IGP_IDX_DIR), 16'h0);
		rd(ad(0, `IGP_IDX_PEND), 16'h0);
		rd(ad(0, `IGP_IDX_LVL), 16'h1234);
		for (int p = 0; p < 3; p++) begin
			wr(ad(p, `IGP_IDX_DIR), 16'hffff);
			rd(ad(p, `IGP_IDX_DIR), p == 2 ? 16'h3fff : 16'hffff);
		end
		wr(ad(0, `IGP_IDX_OUT), 16'ha5a5);
		wt(0);
		chk(out0, 16'ha5a5);
		chk(oen0, 16'h0);
		// bit 0 handed to a peripheral: port stops driving it
		wr(ad(0, `IGP_IDX_PSEL), 16'h0001);
		wt(3);
		chk(oen0, 16'h0001);
		chk(psel0, 16'h0001);
		rd(ad(0, `IGP_IDX_LVL), 16'ha5a4);
		wr(ad(0, `IGP_IDX_PSEL), 16'h0);
		wr(ad(0, `IGP_IDX_SET), 16'h000f);
		rd(ad(0, `IGP_IDX_OUT), 16'ha5af);
		wr(ad(0, `IGP_IDX_CLR), 16'h00a0);
		rd(ad(0, `IGP_IDX_OUT), 16'ha50f);
		rd(ad(0, `IGP_IDX_SET), 16'h0);
		rd(ad(0, 5'h0c), 16'h0);
		rd(16'h1234, 16'h0);
		// engine b: data 2 to pin 14, engine a: data 3 to pin 4
		wr(ad(0, `IGP_IDX_MAP), 16'h2e34);
		rd(ad(0, `IGP_IDX_MAP), 16'h2e34);
		wr(ad(0, `IGP_IDX_ENGA), 16'h0008);
		wr(ad(0, `IGP_IDX_ENGB), 16'h0004);
		rd(ad(0, `IGP_IDX_OUT), 16'he51f);
		wt(3);
		rd(ad(0, `IGP_IDX_ENGA), 16'h0008);
		rd(ad(0, `IGP_IDX_ENGB), 16'h0004);
		// port 1 as inputs: rise on bit 0, fall on bit 1
		wr(ad(1, `IGP_IDX_DIR), 16'h0);
		wr(ad(1, `IGP_IDX_RISE), 16'h0001);
		wr(ad(1, `IGP_IDX_FALL), 16'h0002);
		ext1 <= 16'h0003;
		wt(5);
		chk(oen1, 16'hffff);
		chk(16'(irq1), 16'h0001);
		rd(ad(1, `IGP_IDX_PEND), 16'h0001);
		@(posedge clk);
		ext1 <= 16'h0;
		wt(5);
		rd(ad(1, `IGP_IDX_PEND), 16'h0003);
		wr(ad(1, `IGP_IDX_PEND), 16'h0001);
		rd(ad(1, `IGP_IDX_PEND), 16'h0002);
		chk(16'(irq1), 16'h0001);
		wr(ad(1, `IGP_IDX_PEND), 16'h0002);
		rd(ad(1, `IGP_IDX_PEND), 16'h0);
		chk(16'(irq1), 16'h0);
		// falling edge made by the port itself on an output pin
		wr(ad(2, `IGP_IDX_FALL), 16'h2000);
		wr(ad(2, `IGP_IDX_OUT), 16'h2000);
		wt(5);
		chk(16'(out2), 16'h2000);
		chk(16'(irq2), 16'h0);
		wr(ad(2, `IGP_IDX_CLR), 16'h2000);
		wt(5);
		rd(ad(2, `IGP_IDX_PEND), 16'h2000);
		chk(16'(irq2), 16'h0001);
		chk(16'(irq0), 16'h0);
		give_verdict();
	end
endmodule : test_interruptible_gpio_ports
